// ===== host_port_regs.vh
// Constants for the serial host port and status pin block.
// Included by the host port design file only; holds definitions only.
`ifndef HOST_PORT_REGS_VH
`define HOST_PORT_REGS_VH

// Reset values of synchronised pins
`define SYNC_RST_PIN_INIT      1'h1
`define SYNC_OE_PIN_INIT       1'h0
`define SYNC_SEL_PIN_INIT      1'h1
`define SYNC_SERIAL_INIT       4'hF
`define SYNC_STATUS_INIT       6'h3E

// Status field positions
`define ST_LOCK                0
`define ST_LOS0                1
`define ST_LOS3                4
`define ST_XTAL                5
`define ST_WIDTH               6

// Strap encoding
`define SEL_I2C                1'h1
`define SEL_SPI                1'h0

// Serial engine states
`define S_IDLE                 2'h0
`define S_ADDR                 2'h1
`define S_WR                   2'h2
`define S_RD                   2'h3

// Bit counts within a byte frame
`define BITS_BYTE              4'h8
`define BITS_ACK               4'h9
`define BITS_LAST              4'h7

// Upper five bits of the 7-bit target address, arbitrary value
`define I2C_ADDR_UPPER         5'h0D

`endif

// ===== sync2.v
// Two-stage synchroniser for a group of pins.
// Assumes a synchronous active-high reset on the sampling clock.
`timescale 1ns/100ps
module sync2 #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
)(
  // Clock and reset
  input  wire             clk,
  input  wire             rst,
  // Pins in, synchronised out
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_reg;

  // First stage is read only by the second
  always @(posedge clk)
  begin
    if (rst)
    begin
      meta_reg <= INIT;
      sync_out <= INIT;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // sync2

// ===== host_port_and_status_pins.v
// Serial host port pin muxing, status pins, reset and output disable.
// Assumes status levels come from other clock domains and a host on the pins.
`timescale 1ns/100ps
`include "host_port_regs.vh"
module host_port_and_status_pins (
  // Clock and reset
  input  wire       core_clk,
  input  wire       rst,
  // Control pins
  input  wire       device_reset_n,
  input  wire       output_disable_pin,
  input  wire       iface_select_pin,
  // Serial pins
  input  wire       serial_clk_pin,
  input  wire       serial_data_in,
  output reg        serial_data_out,
  output reg        serial_data_oe_n,
  input  wire       addr_high_or_data_out_pin_in,
  output reg        addr_high_or_data_out_pin_out,
  output reg        addr_high_or_data_out_pin_oe_n,
  input  wire       addr_low_or_select_pin,
  // Configuration
  input  wire       spi_three_wire,
  input  wire       spi_three_wire_read,
  // Byte port to register logic
  output reg  [7:0] rx_byte,
  output reg        rx_valid,
  output reg        rx_is_addr,
  input  wire [7:0] tx_byte,
  output reg        tx_load,
  // Status sources
  input  wire       pll_locked,
  input  wire [3:0] ref_los,
  input  wire       crystal_los,
  input  wire [5:0] status_clear,
  // Status and control outputs
  output reg        status_change_irq_n,
  output reg        loop_unlocked_n,
  output reg        loop_unlocked_alt_n,
  output reg        ref0_signal_loss_n,
  output reg        ref1_signal_loss_n,
  output reg        ref2_signal_loss_n,
  output reg        ref3_signal_loss_n,
  output reg        crystal_signal_loss_n,
  output reg        clk_outputs_enable,
  output reg        logic_reset,
  output reg        i2c_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers
  wire       rst_pin_s;
  wire       oe_pin_s;
  wire       sel_pin_s;
  wire [3:0] ser_s;
  wire [5:0] st_s;

  sync2 #(.WIDTH(1), .INIT(`SYNC_RST_PIN_INIT)) u_sync_rst (
    .clk      (core_clk),
    .rst      (rst),
    .async_in (device_reset_n),
    .sync_out (rst_pin_s)
  );
  sync2 #(.WIDTH(1), .INIT(`SYNC_OE_PIN_INIT)) u_sync_oe (
    .clk      (core_clk),
    .rst      (rst),
    .async_in (output_disable_pin),
    .sync_out (oe_pin_s)
  );
  sync2 #(.WIDTH(1), .INIT(`SYNC_SEL_PIN_INIT)) u_sync_sel (
    .clk      (core_clk),
    .rst      (1'b0), // Left running so the strap is seen while in reset
    .async_in (iface_select_pin),
    .sync_out (sel_pin_s)
  );
  sync2 #(.WIDTH(4), .INIT(`SYNC_SERIAL_INIT)) u_sync_ser (
    .clk      (core_clk),
    .rst      (rst),
    .async_in ({serial_clk_pin, serial_data_in, addr_high_or_data_out_pin_in, addr_low_or_select_pin}),
    .sync_out (ser_s)
  );
  sync2 #(.WIDTH(6), .INIT(`SYNC_STATUS_INIT)) u_sync_st (
    .clk      (core_clk),
    .rst      (1'b0), // Left running so no false change follows reset
    .async_in ({crystal_los, ref_los, pll_locked}),
    .sync_out (st_s)
  );

  wire sclk_s = ser_s[3];
  wire sda_s  = ser_s[2];
  wire a1_s   = ser_s[1];
  wire a0_s   = ser_s[0];

  ////////////////////////////////////////////////////////////////////////////
  // Reset, strap and output enable
  // Reset pin and core reset both reset every register below; i2c_mode and st_prev_reg instead load the strap and the status
  wire int_rst = rst | ~rst_pin_s;

  always @(posedge core_clk)
  begin
    logic_reset <= int_rst;
    // Strap is caught while in reset, so a mid-transfer change cannot corrupt a frame
    if (int_rst)
      i2c_mode <= (sel_pin_s == `SEL_I2C);
    // Outputs off during reset and while disable pin is high
    if (int_rst)
      clk_outputs_enable <= 1'b0;
    else
      clk_outputs_enable <= ~oe_pin_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status pins and change flags
  reg [5:0] st_prev_reg;
  reg [5:0] flags_reg;
  reg [5:0] flags_next;

  always @*
  begin
    // Set wins over a clear in the same cycle
    flags_next = (flags_reg & ~status_clear) | (st_s ^ st_prev_reg);
  end

  always @(posedge core_clk)
  begin
    if (int_rst)
    begin
      st_prev_reg           <= st_s;
      flags_reg             <= 6'h00;
      status_change_irq_n   <= 1'b1;
      loop_unlocked_n       <= 1'b0;
      loop_unlocked_alt_n   <= 1'b0;
      ref0_signal_loss_n    <= 1'b1;
      ref1_signal_loss_n    <= 1'b1;
      ref2_signal_loss_n    <= 1'b1;
      ref3_signal_loss_n    <= 1'b1;
      crystal_signal_loss_n <= 1'b1;
    end
    else
    begin
      st_prev_reg           <= st_s;
      flags_reg             <= flags_next;
      status_change_irq_n   <= ~|flags_next;
      loop_unlocked_n       <= st_s[`ST_LOCK];
      loop_unlocked_alt_n   <= st_s[`ST_LOCK];
      ref0_signal_loss_n    <= ~st_s[`ST_LOS0];
      ref1_signal_loss_n    <= ~st_s[`ST_LOS0+1];
      ref2_signal_loss_n    <= ~st_s[`ST_LOS0+2];
      ref3_signal_loss_n    <= ~st_s[`ST_LOS3];
      crystal_signal_loss_n <= ~st_s[`ST_XTAL];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial engine
  // Pin edges are seen 2-3 core cycles late; fine for an 80 ns serial clock
  reg       sclk_d_reg;
  reg       sda_d_reg;
  reg       cs_d_reg;
  reg [1:0] state_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] sh_rx_reg;
  reg [7:0] sh_tx_reg;
  reg       rw_reg;
  reg       nack_reg;

  wire sclk_rise = sclk_s & ~sclk_d_reg;
  wire sclk_fall = ~sclk_s & sclk_d_reg;
  wire i2c_start = i2c_mode & sclk_s & sclk_d_reg & sda_d_reg & ~sda_s;
  wire i2c_stop  = i2c_mode & sclk_s & sclk_d_reg & ~sda_d_reg & sda_s;
  wire cs_fall   = ~i2c_mode & cs_d_reg & ~a0_s;
  wire cs_rise   = ~i2c_mode & ~cs_d_reg & a0_s;
  // 7-bit address: fixed upper bits then the two address pins
  wire [6:0] my_addr  = {`I2C_ADDR_UPPER, a1_s, a0_s};
  wire [7:0] rx_shift = {sh_rx_reg[6:0], i2c_mode ? sda_s : (spi_three_wire ? sda_s : sda_s)};
  // In 4-wire mode the data pin is an input only
  wire spi_drive_data = spi_three_wire & spi_three_wire_read;

  always @(posedge core_clk)
  begin
    if (int_rst)
    begin
      sclk_d_reg                     <= 1'b0;
      sda_d_reg                      <= 1'b1;
      cs_d_reg                       <= 1'b1;
      state_reg                      <= `S_IDLE;
      bit_cnt_reg                    <= 4'h0;
      sh_rx_reg                      <= 8'h00;
      sh_tx_reg                      <= 8'h00;
      rw_reg                         <= 1'b0;
      nack_reg                       <= 1'b0;
      rx_byte                        <= 8'h00;
      rx_valid                       <= 1'b0;
      rx_is_addr                     <= 1'b0;
      tx_load                        <= 1'b0;
      serial_data_out                <= 1'b0;
      serial_data_oe_n               <= 1'b1;
      addr_high_or_data_out_pin_out  <= 1'b0;
      addr_high_or_data_out_pin_oe_n <= 1'b1;
    end
    else
    begin
      sclk_d_reg <= sclk_s;
      sda_d_reg  <= sda_s;
      cs_d_reg   <= a0_s;
      rx_valid   <= 1'b0;
      tx_load    <= 1'b0;
      if (i2c_mode)
      begin
        // Open-drain data line, address-high pin is an input
        serial_data_out                <= 1'b0;
        addr_high_or_data_out_pin_oe_n <= 1'b1;
        if (i2c_stop)
        begin
          state_reg        <= `S_IDLE;
          serial_data_oe_n <= 1'b1;
        end
        else if (i2c_start)
        begin
          state_reg        <= `S_ADDR;
          bit_cnt_reg      <= 4'h0;
          serial_data_oe_n <= 1'b1;
        end
        else if (state_reg != `S_IDLE)
        begin
          if (sclk_rise)
          begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg < `BITS_BYTE)
              sh_rx_reg <= rx_shift;
            else if (state_reg == `S_RD)
              nack_reg <= sda_s;
          end
          else if (sclk_fall)
          begin
            if (bit_cnt_reg == `BITS_BYTE)
            begin
              case (state_reg)
                `S_ADDR:
                begin
                  if (sh_rx_reg[7:1] == my_addr)
                  begin
                    rw_reg           <= sh_rx_reg[0];
                    nack_reg         <= 1'b0;
                    serial_data_oe_n <= 1'b0;
                    rx_byte          <= sh_rx_reg;
                    rx_valid         <= 1'b1;
                    rx_is_addr       <= 1'b1;
                  end
                  else
                    state_reg <= `S_IDLE;
                end
                `S_WR:
                begin
                  serial_data_oe_n <= 1'b0;
                  rx_byte          <= sh_rx_reg;
                  rx_valid         <= 1'b1;
                  rx_is_addr       <= 1'b0;
                end
                default:
                  serial_data_oe_n <= 1'b1;
              endcase
            end
            else if (bit_cnt_reg == `BITS_ACK)
            begin
              bit_cnt_reg <= 4'h0;
              if ((state_reg == `S_ADDR && rw_reg) || (state_reg == `S_RD && !nack_reg))
              begin
                state_reg        <= `S_RD;
                sh_tx_reg        <= tx_byte;
                tx_load          <= 1'b1;
                serial_data_oe_n <= tx_byte[7];
              end
              else if (state_reg == `S_RD)
              begin
                // Host refused more data
                state_reg        <= `S_IDLE;
                serial_data_oe_n <= 1'b1;
              end
              else
              begin
                state_reg        <= `S_WR;
                serial_data_oe_n <= 1'b1;
              end
            end
            else if (state_reg == `S_RD && bit_cnt_reg != 4'h0)
            begin
              sh_tx_reg        <= {sh_tx_reg[6:0], 1'b0};
              serial_data_oe_n <= sh_tx_reg[6];
            end
          end
        end
      end
      else
      begin
        state_reg <= `S_IDLE;
        if (cs_rise)
        begin
          serial_data_oe_n               <= 1'b1;
          addr_high_or_data_out_pin_oe_n <= 1'b1;
        end
        else if (cs_fall)
        begin
          // Frame opens with the first byte already on the output
          bit_cnt_reg                    <= 4'h0;
          sh_tx_reg                      <= tx_byte;
          tx_load                        <= 1'b1;
          serial_data_out                <= tx_byte[7];
          serial_data_oe_n               <= ~spi_drive_data;
          addr_high_or_data_out_pin_out  <= tx_byte[7];
          addr_high_or_data_out_pin_oe_n <= spi_three_wire;
        end
        else if (!a0_s)
        begin
          if (sclk_rise)
          begin
            sh_rx_reg <= rx_shift;
            if (bit_cnt_reg == `BITS_LAST)
            begin
              bit_cnt_reg <= 4'h0;
              rx_byte     <= rx_shift;
              rx_valid    <= 1'b1;
              rx_is_addr  <= 1'b0;
            end
            else
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          else if (sclk_fall)
          begin
            if (bit_cnt_reg == 4'h0)
            begin
              sh_tx_reg                     <= tx_byte;
              tx_load                       <= 1'b1;
              serial_data_out               <= tx_byte[7];
              addr_high_or_data_out_pin_out <= tx_byte[7];
            end
            else
            begin
              sh_tx_reg                     <= {sh_tx_reg[6:0], 1'b0};
              serial_data_out               <= sh_tx_reg[6];
              addr_high_or_data_out_pin_out <= sh_tx_reg[6];
            end
          end
        end
      end
    end
  end

endmodule // host_port_and_status_pins

// ===== hpsp_chk.sv
// Checker for the host port and status pins: pin-level timing relations.
// Sees top ports only; bound from the bench top file.
`timescale 1ns/100ps
module hpsp_chk (
  // Clock and reset
  input wire       core_clk,
  input wire       rst,
  input wire       device_reset_n,
  // Control and status in
  input wire       output_disable_pin,
  input wire       iface_select_pin,
  input wire       pll_locked,
  input wire [3:0] ref_los,
  input wire       crystal_los,
  input wire [5:0] status_clear,
  // Pins out
  input wire       status_change_irq_n,
  input wire       loop_unlocked_n,
  input wire       loop_unlocked_alt_n,
  input wire       ref0_signal_loss_n,
  input wire       crystal_signal_loss_n,
  input wire       clk_outputs_enable,
  input wire       logic_reset,
  input wire       i2c_mode
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  a_reset_blanks: assert property (logic_reset |-> !clk_outputs_enable)
    else $error("outputs on in reset");
  // Two cycles of margin over the synchroniser delay
  a_oe_blanks: assert property (output_disable_pin[*5] |-> !clk_outputs_enable)
    else $error("outputs on while disabled");
  a_lock_follow: assert property ((!logic_reset && $stable(pll_locked))[*6] |->
    loop_unlocked_n == pll_locked && loop_unlocked_alt_n == pll_locked)
    else $error("lock pin wrong");
  a_ref_follow: assert property ((!logic_reset && $stable(ref_los))[*6] |->
    ref0_signal_loss_n == !ref_los[0])
    else $error("input loss pin wrong");
  a_xtal_follow: assert property ((!logic_reset && $stable(crystal_los))[*6] |->
    crystal_signal_loss_n == !crystal_los)
    else $error("crystal loss pin wrong");
  a_irq_on_change: assert property ((!logic_reset)[*6] ##0 $changed(loop_unlocked_n) |->
    ##[0:3] !status_change_irq_n)
    else $error("no interrupt on change");
  a_irq_holds: assert property (!status_change_irq_n && status_clear == 6'h00 && device_reset_n |=>
    !status_change_irq_n)
    else $error("interrupt dropped");
  a_irq_clears: assert property ((status_clear == 6'h3F && $stable({pll_locked, ref_los, crystal_los}))[*6]
    |-> status_change_irq_n)
    else $error("interrupt stuck");
  a_strap_latch: assert property ((logic_reset && $stable(iface_select_pin))[*5] |=>
    i2c_mode == $past(iface_select_pin))
    else $error("mode not latched");
  c_irq: cover property ($fell(status_change_irq_n));
  c_i2c: cover property ($rose(i2c_mode));
  c_oe: cover property ($fell(clk_outputs_enable) && !logic_reset);
endmodule // hpsp_chk

// ===== serial_host_model.sv
// Host controller model for the shared serial pins: SPI mode 0 and I2C.
// Assumes one device; I2C data has a board pull-up, A1 tied high.
`timescale 1ns/100ps
module serial_host_model (
  // From the device
  input  wire i2c_mode,
  input  wire serial_data_out,
  input  wire serial_data_oe_n,
  input  wire addr_high_or_data_out_pin_out,
  input  wire addr_high_or_data_out_pin_oe_n,
  // To the device
  output reg  serial_clk_pin,
  output reg  addr_low_or_select_pin,
  output wire serial_data_in,
  output wire addr_high_or_data_out_pin_in
);
  reg hd = 1'b1;
  reg last = 1'b0;
  // Open drain in I2C; a released SPI output shows the inverse of its last bit
  assign serial_data_in = serial_data_oe_n ? hd : serial_data_out & (hd | !i2c_mode);
  assign addr_high_or_data_out_pin_in = addr_high_or_data_out_pin_oe_n ? i2c_mode | !last
    : addr_high_or_data_out_pin_out;
  initial
  begin
    serial_clk_pin = 1'b0;
    addr_low_or_select_pin = 1'b1;
  end
  ////////////////////////////////////////
  task spi_xfer(input [7:0] tx, input sel, output [7:0] rx);
    integer i;
    begin
      addr_low_or_select_pin = sel;
      #80;
      for (i = 7; i >= 0; i = i - 1)
      begin
        hd = tx[i];
        #40 serial_clk_pin = 1'b1;
        #20 rx[i] = addr_high_or_data_out_pin_oe_n ? serial_data_in : addr_high_or_data_out_pin_in;
        last = rx[i];
        #20 serial_clk_pin = 1'b0;
      end
      #80 addr_low_or_select_pin = 1'b1;
      #80;
    end
  endtask
  task i2c_byte(input [7:0] tx, input start, output ack, output [7:0] rd);
    integer i;
    reg [8:0] sh;
    reg [8:0] seen;
    begin
      sh = {tx, 1'b1};
      seen = 9'h000;
      if (start)
      begin
        addr_low_or_select_pin = 1'b0;
        hd = 1'b1;
        #20 serial_clk_pin = 1'b1;
        #80 hd = 1'b0;
        #40 serial_clk_pin = 1'b0;
      end
      for (i = 0; i < 9; i = i + 1)
      begin
        #20 hd = sh[8];
        sh = sh << 1;
        #20 serial_clk_pin = 1'b1;
        #40 seen = {seen[7:0], serial_data_in};
        serial_clk_pin = 1'b0;
      end
      ack = !seen[0];
      rd = seen[8:1];
    end
  endtask
  task i2c_stop;
    begin
      #20 hd = 1'b0;
      #20 serial_clk_pin = 1'b1;
      #40 hd = 1'b1;
      #80;
    end
  endtask
endmodule // serial_host_model

// ===== tb_host_port_and_status_pins.sv
// Bench: resets, SPI and I2C transfers, status pins, interrupt, output disable.
// Needs the host model and the checker.
`timescale 1ns/100ps
module tb_host_port_and_status_pins;
  reg        core_clk, rst, device_reset_n, output_disable_pin, iface_select_pin;
  reg  [7:0] tx_byte;
  reg        pll_locked, crystal_los;
  reg  [3:0] ref_los;
  reg  [5:0] status_clear;
  reg        spi_three_wire, spi_three_wire_read;
  wire       tx_load, rx_is_addr;
  wire [7:0] rx_byte;
  wire       rx_valid, status_change_irq_n, loop_unlocked_n, loop_unlocked_alt_n;
  wire       ref0_signal_loss_n, ref1_signal_loss_n, ref2_signal_loss_n, ref3_signal_loss_n;
  wire       crystal_signal_loss_n, clk_outputs_enable, logic_reset, i2c_mode;
  wire       serial_clk_pin, serial_data_in, serial_data_out, serial_data_oe_n;
  wire       addr_high_or_data_out_pin_in, addr_high_or_data_out_pin_out;
  wire       addr_high_or_data_out_pin_oe_n, addr_low_or_select_pin;
  wire [7:0] st_pins = {1'b0, loop_unlocked_n, loop_unlocked_alt_n, ref3_signal_loss_n,
    ref2_signal_loss_n, ref1_signal_loss_n, ref0_signal_loss_n, crystal_signal_loss_n};
  integer    error_cnt, n_compared, n_rx, n_ld, j;
  reg  [7:0] rx;
  reg  [5:0] pat;
  reg        ack;
  // Strap mode changes only through reset; SPI wire count is a live level
  host_port_and_status_pins u_dut (
    .core_clk, .rst, .device_reset_n, .output_disable_pin, .iface_select_pin,
    .serial_clk_pin, .serial_data_in, .serial_data_out, .serial_data_oe_n,
    .addr_high_or_data_out_pin_in, .addr_high_or_data_out_pin_out,
    .addr_high_or_data_out_pin_oe_n, .addr_low_or_select_pin,
    .spi_three_wire, .spi_three_wire_read, .rx_byte, .rx_valid,
    .rx_is_addr, .tx_byte, .tx_load, .pll_locked, .ref_los, .crystal_los,
    .status_clear, .status_change_irq_n, .loop_unlocked_n, .loop_unlocked_alt_n,
    .ref0_signal_loss_n, .ref1_signal_loss_n, .ref2_signal_loss_n, .ref3_signal_loss_n,
    .crystal_signal_loss_n, .clk_outputs_enable, .logic_reset, .i2c_mode);
  serial_host_model u_host (
    .i2c_mode, .serial_data_out, .serial_data_oe_n, .addr_high_or_data_out_pin_out,
    .addr_high_or_data_out_pin_oe_n, .serial_clk_pin, .addr_low_or_select_pin,
    .serial_data_in, .addr_high_or_data_out_pin_in);
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    if (rx_valid === 1'b1)
      n_rx <= n_rx + 1;
    if (tx_load === 1'b1)
      n_ld <= n_ld + 1;
  end
  ////////////////////////////////////////
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge core_clk);
  endtask
  task look(input integer n);
    begin
      cyc(n);
      #1;
    end
  endtask
  task end_of_test;
    begin
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // Bounded wait for internal reset to end
  task wait_run;
    integer k;
    begin
      k = 0;
      while (logic_reset !== 1'b0 && k < 40)
      begin
        cyc(1);
        k = k + 1;
      end
      if (k == 40)
      begin
        chk({7'h00, logic_reset}, 8'h00);
        end_of_test;
      end
      look(4);
    end
  endtask
  ////////////////////////////////////////
  initial
  begin
    error_cnt = 0;
    n_compared = 0;
    n_rx = 0;
    n_ld = 0;
    rst = 1'b1;
    device_reset_n = 1'b1;
    output_disable_pin = 1'b0;
    iface_select_pin = 1'b0;
    tx_byte = 8'hA5;
    {pll_locked, ref_los, crystal_los} = 6'h00;
    status_clear = 6'h00;
    spi_three_wire = 1'b0;
    spi_three_wire_read = 1'b0;
    look(9);
    chk({6'h00, logic_reset, clk_outputs_enable}, 8'h02);
    cyc(1);
    rst <= 1'b0;
    wait_run;
    chk({6'h00, i2c_mode, status_change_irq_n}, 8'h01);
    u_host.spi_xfer(8'h3C, 1'b0, rx);
    chk(rx, 8'hA5);
    chk(rx_byte, 8'h3C);
    chk(n_ld[7:0], 8'h02);
    u_host.spi_xfer(8'hC3, 1'b1, rx);
    chk(n_rx[7:0], 8'h01);
    cyc(1);
    spi_three_wire <= 1'b1;
    spi_three_wire_read <= 1'b1;
    look(1);
    u_host.spi_xfer(8'h00, 1'b0, rx);
    chk(rx, 8'hA5);
    for (j = 0; j < 2; j = j + 1)
    begin
      pat = j ? 6'h14 : 6'h2B;
      cyc(1);
      {pll_locked, ref_los, crystal_los} <= pat;
      look(8);
      chk(st_pins, {1'b0, pat[5], pat[5], ~pat[4:0]});
      chk({7'h00, status_change_irq_n}, 8'h00);
      cyc(1);
      status_clear <= 6'h3F;
      look(7);
      chk({7'h00, status_change_irq_n}, 8'h01);
      cyc(1);
      status_clear <= 6'h00;
    end
    output_disable_pin <= 1'b1;
    look(6);
    chk({7'h00, clk_outputs_enable}, 8'h00);
    cyc(1);
    output_disable_pin <= 1'b0;
    look(6);
    chk({7'h00, clk_outputs_enable}, 8'h01);
    cyc(1);
    device_reset_n <= 1'b0;
    iface_select_pin <= 1'b1;
    look(6);
    chk({6'h00, logic_reset, clk_outputs_enable}, 8'h02);
    chk(st_pins, 8'h1F);
    cyc(1);
    device_reset_n <= 1'b1;
    wait_run;
    chk({6'h00, i2c_mode, status_change_irq_n}, 8'h03);
    u_host.i2c_byte(8'h6C, 1'b1, ack, rx);
    chk({7'h00, ack}, 8'h01);
    chk({rx_is_addr, rx_byte[7:1]}, 8'hB6);
    u_host.i2c_byte(8'h5A, 1'b0, ack, rx);
    chk({7'h00, ack}, 8'h01);
    chk(rx_byte, 8'h5A);
    chk({7'h00, rx_is_addr}, 8'h00);
    u_host.i2c_stop;
    u_host.i2c_byte(8'h6E, 1'b1, ack, rx);
    chk({7'h00, ack}, 8'h00);
    u_host.i2c_stop;
    u_host.i2c_byte(8'h6D, 1'b1, ack, rx);
    chk({7'h00, ack}, 8'h01);
    u_host.i2c_byte(8'hFF, 1'b0, ack, rx);
    chk(rx, 8'hA5);
    chk({7'h00, serial_data_oe_n}, 8'h01);
    u_host.i2c_stop;
    end_of_test;
  end
endmodule // tb_host_port_and_status_pins
bind host_port_and_status_pins hpsp_chk u_chk (
  .core_clk, .rst, .device_reset_n, .output_disable_pin, .iface_select_pin, .pll_locked,
  .ref_los, .crystal_los, .status_clear, .status_change_irq_n, .loop_unlocked_n,
  .loop_unlocked_alt_n, .ref0_signal_loss_n, .crystal_signal_loss_n, .clk_outputs_enable,
  .logic_reset, .i2c_mode);
